//--- hw/crbf_pkg.sv
// Behaviour
// - Legacy code 11 accepts everything, filters ignored.
// - Legacy code 10 takes valid extended identifiers.
// - Legacy code 01 takes valid standard identifiers.
// - Legacy code 00 follows filter identifier type.
// - Two-bit mask select per filter 12..15.
// - Mask select exists only in enhanced modes.
package crbf_pkg;

	localparam int unsigned ADDR_W = 12;

	// Register byte offsets.
	localparam logic [11:0] OFS_CTRL  = 12'h000;
	localparam logic [11:0] OFS_MSEL  = 12'h004;
	localparam logic [11:0] OFS_MODE  = 12'h008;
	localparam logic [11:0] OFS_STAT  = 12'h00C;
	localparam logic [11:0] OFS_IMASK = 12'h010;

	// Control register field positions.
	localparam int unsigned CTRL_FULL_BIT   = 7;
	localparam int unsigned CTRL_RXM_HI_BIT = 6;
	localparam int unsigned CTRL_RXM_LO_BIT = 5;
	localparam int unsigned CTRL_RTR_LEG    = 3;
	localparam int unsigned CTRL_RTR_ENH    = 5;
	localparam int unsigned HIT_W_LEG       = 3;
	localparam int unsigned HIT_W_ENH       = 5;

	// Status and mask bit positions.
	localparam int unsigned EVT_STORED  = 0;
	localparam int unsigned EVT_DROPPED = 1;
	localparam int unsigned EVT_W       = 2;

	// Values after reset.
	localparam logic [1:0] RXM_RESET   = 2'h0;
	localparam logic [7:0] MSEL_RESET  = 8'h00;
	localparam logic [1:0] MODE_RESET  = 2'h0;
	localparam logic [1:0] IMASK_RESET = 2'h0;

	// Receive mode codes.
	localparam logic [1:0] RXM_ALL = 2'h3;
	localparam logic [1:0] RXM_EXT = 2'h2;
	localparam logic [1:0] RXM_STD = 2'h1;
	localparam logic [1:0] RXM_FLT = 2'h0;

	// Mask select codes.
	localparam logic [1:0] MSEL_NONE  = 2'h3;
	localparam logic [1:0] MSEL_FIL15 = 2'h2;
	localparam logic [1:0] MSEL_MASK1 = 2'h1;
	localparam logic [1:0] MSEL_MASK0 = 2'h0;

	// Operating modes.
	localparam logic [1:0] MODE_LEGACY = 2'h0;

endpackage

//--- hw/crbf_accept.sv
`timescale 1ns/1ns
module crbf_accept
	import crbf_pkg::*;
(
	// Configuration.
	input  wire logic       i_enhanced,
	input  wire logic [1:0] i_rxm,
	// Incoming message attributes.
	input  wire logic       i_msg_err,
	input  wire logic       i_msg_ext,
	input  wire logic       i_hit_valid,
	input  wire logic       i_extended_identifier_enable,
	// Decision.
	output logic            o_accept
);

	always_comb begin
		o_accept = 1'b0;
		if (i_enhanced) begin
			o_accept = i_rxm[1] | (!i_msg_err & i_hit_valid);
		end else begin
			unique case (i_rxm)
				RXM_ALL: o_accept = 1'b1;
				RXM_EXT: o_accept = !i_msg_err & i_hit_valid & i_msg_ext & i_extended_identifier_enable;
				RXM_STD: o_accept = !i_msg_err & i_hit_valid & !i_msg_ext & !i_extended_identifier_enable;
				RXM_FLT: o_accept = !i_msg_err & i_hit_valid & (i_msg_ext == i_extended_identifier_enable);
			endcase
		end
	end

endmodule

//--- hw/crbf_top.sv
// The APB slave port and the address map were decided locally.
`timescale 1ns/1ns
module crbf_top
	import crbf_pkg::*;
(
	// Clock and reset.
	input  wire logic              i_clk,
	input  wire logic              i_reset_n,
	// APB slave.
	input  wire logic              i_psel,
	input  wire logic              i_penable,
	input  wire logic              i_pwrite,
	input  wire logic [ADDR_W-1:0] i_paddr,
	input  wire logic [31:0]       i_pwdata,
	output logic [31:0]            o_prdata,
	output logic                   o_pready,
	output logic                   o_pslverr,
	// Message from the receive engine.
	input  wire logic              i_msg_valid,
	input  wire logic              i_msg_err,
	input  wire logic              i_msg_ext,
	input  wire logic              i_msg_rtr,
	input  wire logic              i_hit_valid,
	input  wire logic [4:0]        i_hit_num,
	input  wire logic              i_extended_identifier_enable,
	// Buffer and filter control.
	output logic                   o_buf_load,
	output logic                   o_buffer_full,
	output logic [7:0]             o_mask_sel,
	output logic                   o_irq
);

	logic             full_q;
	logic [1:0]       rxm_q;
	logic             rtr_q;
	logic [4:0]       hit_q;
	logic [7:0]       msel_q;
	logic [1:0]       mode_q;
	logic [EVT_W-1:0] stat_q;
	logic [EVT_W-1:0] imask_q;
	logic             load_q;
	logic             pready_q;
	logic             pslverr_q;
	logic [31:0]      prdata_q;
	logic [7:0]       mask_sel_q;
	logic             irq_q;

	logic             enhanced;
	logic             accept;
	logic             store;
	logic             drop;
	logic             setup;
	logic             wr_en;
	logic [7:0]       ctrl_rd;
	logic             mapped;
	logic [EVT_W-1:0] evt;

	assign enhanced = (mode_q != MODE_LEGACY);
	assign setup    = i_psel & !i_penable;
	assign wr_en    = i_psel & i_penable & pready_q & i_pwrite;

	crbf_accept u_accept (
		.i_enhanced  (enhanced),
		.i_rxm       (rxm_q),
		.i_msg_err   (i_msg_err),
		.i_msg_ext   (i_msg_ext),
		.i_hit_valid (i_hit_valid),
		.i_extended_identifier_enable    (i_extended_identifier_enable),
		.o_accept    (accept)
	);

	// A full buffer takes nothing new.
	// Load gated by full.
	assign store = i_msg_valid & accept & !full_q;
	assign drop  = i_msg_valid & accept & full_q;
	assign evt   = {drop, store};

	function automatic logic is_mapped(input logic [ADDR_W-1:0] a, input logic enh);
		is_mapped = (a == OFS_CTRL) || (a == OFS_MODE) || (a == OFS_STAT)
			|| (a == OFS_IMASK) || (enh && (a == OFS_MSEL));
	endfunction

	assign mapped = is_mapped(i_paddr, enhanced);

	// Full flag: hardware set wins over a software clear.
	// Set on store, cleared by software.
	always_ff @(posedge i_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			full_q <= 1'b0;
		end else if (store) begin
			full_q <= 1'b1;
		end else if (wr_en && i_paddr == OFS_CTRL && !i_pwdata[CTRL_FULL_BIT]) begin
			full_q <= 1'b0;
		end
	end

	// Message attributes captured with the store.
	// Remote request capture.
	always_ff @(posedge i_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			rtr_q <= 1'b0;
			hit_q <= 5'h00;
		end else if (store) begin
			rtr_q <= i_msg_rtr;
			hit_q <= enhanced ? i_hit_num : {2'h0, i_hit_num[HIT_W_LEG-1:0]};
		end
	end

	always_ff @(posedge i_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			load_q <= 1'b0;
		end else begin
			load_q <= store;
		end
	end

	// Receive mode field; enhanced modes only own the upper bit.
	always_ff @(posedge i_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			rxm_q <= RXM_RESET;
		end else if (wr_en && i_paddr == OFS_CTRL) begin
			rxm_q[1] <= i_pwdata[CTRL_RXM_HI_BIT];
			if (!enhanced) begin
				rxm_q[0] <= i_pwdata[CTRL_RXM_LO_BIT];
			end
		end
	end

	always_ff @(posedge i_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			mode_q <= MODE_RESET;
		end else if (wr_en && i_paddr == OFS_MODE) begin
			mode_q <= i_pwdata[1:0];
		end
	end

	// Mask select writes are ignored in legacy mode.
	// Enhanced-only register.
	always_ff @(posedge i_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			msel_q <= MSEL_RESET;
		end else if (wr_en && enhanced && i_paddr == OFS_MSEL) begin
			msel_q <= i_pwdata[7:0];
		end
	end

	// Effective selects for filters 15..12, packed high to low.
	// Packed select fields.
	always_ff @(posedge i_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			mask_sel_q <= MSEL_RESET;
		end else begin
			mask_sel_q <= enhanced ? msel_q : MSEL_RESET;
		end
	end

	// Sticky events, write one to clear, set wins.
	always_ff @(posedge i_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			stat_q <= '0;
		end else if (wr_en && i_paddr == OFS_STAT) begin
			stat_q <= (stat_q & ~i_pwdata[EVT_W-1:0]) | evt;
		end else begin
			stat_q <= stat_q | evt;
		end
	end

	always_ff @(posedge i_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			imask_q <= IMASK_RESET;
		end else if (wr_en && i_paddr == OFS_IMASK) begin
			imask_q <= i_pwdata[EVT_W-1:0];
		end
	end

	always_ff @(posedge i_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			irq_q <= 1'b0;
		end else begin
			irq_q <= |(stat_q & imask_q);
		end
	end

	// Control layout depends on the operating mode.
	// Flag position by mode.
	always_comb begin
		if (enhanced) begin
			ctrl_rd = {full_q, rxm_q[1], rtr_q, hit_q};
		end else begin
			ctrl_rd = {full_q, rxm_q, 1'b0, rtr_q, hit_q[HIT_W_LEG-1:0]};
		end
	end

	// No wait state: data is latched in setup, pready follows.
	always_ff @(posedge i_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			pready_q  <= 1'b0;
			pslverr_q <= 1'b0;
		end else begin
			pready_q  <= setup;
			pslverr_q <= setup & !mapped;
		end
	end

	always_ff @(posedge i_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			prdata_q <= 32'h0000_0000;
		end else if (setup && !i_pwrite) begin
			unique case (1'b1)
				i_paddr == OFS_CTRL: prdata_q <= {24'h00_0000, ctrl_rd};
				i_paddr == OFS_MSEL && enhanced: prdata_q <= {24'h00_0000, msel_q};
				i_paddr == OFS_MODE: prdata_q <= {30'h0000_0000, mode_q};
				i_paddr == OFS_STAT: prdata_q <= {30'h0000_0000, stat_q | evt};
				i_paddr == OFS_IMASK: prdata_q <= {30'h0000_0000, imask_q};
				default: prdata_q <= 32'h0000_0000;
			endcase
		end
	end

	assign o_prdata      = prdata_q;
	assign o_pready      = pready_q;
	assign o_pslverr     = pslverr_q;
	assign o_buf_load    = load_q;
	assign o_buffer_full = full_q;
	assign o_mask_sel    = mask_sel_q;
	assign o_irq         = irq_q;

	default clocking cb @(posedge i_clk);
	endclocking
	default disable iff (!i_reset_n);

	sequence s_msg_stored;
		i_msg_valid && accept && !full_q;
	endsequence

	sequence s_flag_up;
		full_q && o_buf_load;
	endsequence

	a_full_set_on_store: assert property (
		s_msg_stored |=> s_flag_up
	) else $error("full flag not set after store");

	a_no_load_when_full: assert property (
		full_q |=> !o_buf_load
	) else $error("buffer loaded while full");

	a_accept_all_mode: assert property (
		(!enhanced && rxm_q == RXM_ALL && i_msg_valid && !full_q) |=> o_buf_load
	) else $error("legacy all mode dropped a message");

	a_ext_only_mode: assert property (
		(!enhanced && rxm_q == RXM_EXT && i_msg_valid && (!i_msg_ext || !i_extended_identifier_enable || i_msg_err))
		|=> !o_buf_load
	) else $error("extended mode took wrong message");

	a_std_only_mode: assert property (
		(!enhanced && rxm_q == RXM_STD && i_msg_valid && (i_msg_ext || i_extended_identifier_enable || i_msg_err))
		|=> !o_buf_load
	) else $error("standard mode took wrong message");

	a_type_agree_mode: assert property (
		(!enhanced && rxm_q == RXM_FLT && i_msg_valid && i_hit_valid && !i_msg_err
			&& (i_msg_ext == i_extended_identifier_enable) && !full_q) |=> o_buf_load
	) else $error("filter mode missed a matching message");

	a_rtr_captured: assert property (
		s_msg_stored ##0 i_msg_rtr |=> rtr_q ##1 (rtr_q || o_buf_load)
	) else $error("remote request flag not captured");

	a_msel_legacy_off: assert property (
		!enhanced [*2] |-> o_mask_sel == MSEL_RESET
	) else $error("mask select active in legacy mode");

	a_msel_follows: assert property (
		(enhanced && $stable(msel_q)) [*2] |-> o_mask_sel == msel_q
	) else $error("mask select output wrong");

	a_hit_legacy_width: assert property (
		(s_msg_stored ##0 !enhanced) |=> hit_q[4:3] == 2'h0
	) else $error("legacy hit wider than three bits");

	a_irq_level: assert property (
		(|(stat_q & imask_q)) |=> o_irq
	) else $error("interrupt not raised");

	a_pready_pulse: assert property (
		o_pready |=> !o_pready
	) else $error("pready longer than one cycle");

	// Software side of the full handshake.
	sequence s_sw_clear;
		wr_en && i_paddr == OFS_CTRL && !i_pwdata[CTRL_FULL_BIT];
	endsequence

	a_full_sw_clear: assert property (
		s_sw_clear ##0 !store |=> !full_q
	) else $error("full flag not cleared by software");

	a_full_holds: assert property (
		(full_q && !(wr_en && i_paddr == OFS_CTRL)) |=> full_q
	) else $error("full flag dropped without a clear");

	a_drop_flagged: assert property (
		(i_msg_valid && accept && full_q) |=> stat_q[EVT_DROPPED]
	) else $error("dropped frame not flagged");

	// Enhanced modes accept everything when the upper mode bit is set.
	a_enh_accept_all: assert property (
		(enhanced && rxm_q[1] && i_msg_valid && !full_q) |=> o_buf_load
	) else $error("enhanced all mode dropped a message");

	a_rtr_cleared: assert property (
		s_msg_stored ##0 !i_msg_rtr |=> !rtr_q
	) else $error("remote request flag set for data frame");

	a_rtr_enh_pos: assert property (
		enhanced |-> ctrl_rd[CTRL_RTR_ENH] == rtr_q
	) else $error("remote request flag misplaced in enhanced mode");

	a_rtr_leg_pos: assert property (
		!enhanced |-> ctrl_rd[CTRL_RTR_LEG] == rtr_q
	) else $error("remote request flag misplaced in legacy mode");

	a_msel_legacy_wr: assert property (
		(!enhanced && wr_en && i_paddr == OFS_MSEL) |=> $stable(msel_q)
	) else $error("mask select written in legacy mode");

	a_hit_enh_capture: assert property (
		(s_msg_stored ##0 enhanced) |=> hit_q == $past(i_hit_num)
	) else $error("enhanced hit number not captured");

	// An access to a hole answers at once with an error.
	a_bad_addr_err: assert property (
		(setup && !mapped) |=> o_pslverr && o_pready
	) else $error("unmapped access without error");

endmodule

//--- verification/crbf_msg_src.sv
`timescale 1ns/1ns
module crbf_msg_src (
	// Clock.
	input  wire logic       i_clk,
	// Finished frame toward the buffer.
	output logic            o_msg_valid,
	output logic            o_msg_err,
	output logic            o_msg_ext,
	output logic            o_msg_rtr,
	output logic            o_hit_valid,
	output logic [4:0]      o_hit_num,
	output logic            o_extended_identifier_enable
);
	initial begin
		o_msg_valid = 1'b0;
		{o_msg_err, o_msg_ext, o_hit_valid, o_extended_identifier_enable, o_msg_rtr} = 5'h00;
		o_hit_num = 5'h00;
	end

	// Offers one frame, attributes given as {error, extended, hit, extended enable}.
	task automatic send(input logic [3:0] f, input logic rtr, input logic [4:0] hit);
		@(posedge i_clk);
		o_msg_valid <= 1'b1;
		{o_msg_err, o_msg_ext, o_hit_valid, o_extended_identifier_enable} <= f;
		o_msg_rtr <= rtr;
		o_hit_num <= hit;
		@(posedge i_clk);
		o_msg_valid <= 1'b0;
		// Attributes flip after the frame so stale values never pass for fresh ones.
		{o_msg_err, o_msg_ext, o_hit_valid, o_extended_identifier_enable} <= ~f;
		o_msg_rtr <= ~rtr;
		o_hit_num <= ~hit;
	endtask
endmodule

//--- verification/crbf_tb_top.sv
`timescale 1ns/1ns
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin n_fail++; \
	$display("[FAIL] %0t got %h want %h", $time, (a), (b)); end end
module crbf_tb_top
	import crbf_pkg::*;
;
	logic        clk = 1'b0;
	logic        reset_n = 1'b0;
	logic        psel = 1'b0;
	logic        penable = 1'b0;
	logic        pwrite = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	logic        mv, me, mx, mr, hv, ex;
	logic [4:0]  hn;
	logic        buf_load, buffer_full, irq;
	logic [7:0]  mask_sel;
	logic [31:0] rd;
	logic        er;
	int          n_fail = 0;
	int          cmp_count = 0;
	// Row: {enhanced, receive mode, error, extended, hit, extended enable, stored}.
	logic [7:0]  rows [12] = '{8'h71, 8'h4F, 8'h44, 8'h25, 8'h34, 8'h0F,
		8'h0C, 8'h0A, 8'hD1, 8'h85, 8'h80, 8'h94};

	always #4 clk = ~clk;

	crbf_msg_src i_crbf_msg_src (.i_clk(clk), .o_msg_valid(mv), .o_msg_err(me),
		.o_msg_ext(mx), .o_msg_rtr(mr), .o_hit_valid(hv), .o_hit_num(hn), .o_extended_identifier_enable(ex));

	crbf_top i_crbf_top (.i_clk(clk), .i_reset_n(reset_n), .i_psel(psel),
		.i_penable(penable), .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata),
		.o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr), .i_msg_valid(mv),
		.i_msg_err(me), .i_msg_ext(mx), .i_msg_rtr(mr), .i_hit_valid(hv),
		.i_hit_num(hn), .i_extended_identifier_enable(ex), .o_buf_load(buf_load),
		.o_buffer_full(buffer_full), .o_mask_sel(mask_sel), .o_irq(irq));

	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge clk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		do begin
			@(posedge clk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		if (n >= 20) begin
			n_fail++;
			$display("[FAIL] %0t no bus answer", $time);
		end
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic complete_run;
		$display("compares %0d mismatches %0d", cmp_count, n_fail);
		if (n_fail == 0 && cmp_count > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask

	initial begin
		#200000;
		n_fail++;
		complete_run();
	end

	initial begin
		repeat (20) @(posedge clk);
		reset_n <= 1'b1;
		apb(1'b0, OFS_CTRL, 32'h0);
		`CHK(rd, 32'h0)
		`CHK({irq, buffer_full, mask_sel}, 10'h000)
		apb(1'b0, OFS_MSEL, 32'h0);
		`CHK({er, rd}, {1'b1, 32'h0})
		$display("reset test done");
		for (int i = 0; i < 12; i++) begin
			apb(1'b1, OFS_MODE, {31'h0, rows[i][7]});
			apb(1'b1, OFS_CTRL, {25'h0, rows[i][6:5], 5'h00});
			i_crbf_msg_src.send(rows[i][4:1], 1'b0, 5'h01);
			#1;
			`CHK(buf_load, rows[i][0])
			`CHK(buffer_full, rows[i][0])
		end
		$display("acceptance test done");
		apb(1'b1, OFS_MODE, 32'h0);
		apb(1'b1, OFS_STAT, 32'h3);
		apb(1'b1, OFS_CTRL, 32'h60);
		i_crbf_msg_src.send(4'h8, 1'b1, 5'h1D);
		i_crbf_msg_src.send(4'h7, 1'b0, 5'h02);
		#1;
		`CHK(buf_load, 1'b0)
		apb(1'b0, OFS_CTRL, 32'h0);
		`CHK(rd, 32'hED)
		apb(1'b0, OFS_STAT, 32'h0);
		`CHK(rd, 32'h3)
		apb(1'b1, OFS_CTRL, 32'hE0);
		apb(1'b1, OFS_IMASK, 32'h1);
		@(posedge clk);
		#1;
		`CHK({buffer_full, irq}, 2'b11)
		apb(1'b1, OFS_STAT, 32'h1);
		@(posedge clk);
		#1;
		`CHK(irq, 1'b0)
		$display("full test done");
		apb(1'b1, OFS_MODE, 32'h1);
		apb(1'b1, OFS_CTRL, 32'h40);
		i_crbf_msg_src.send(4'h2, 1'b1, 5'h1D);
		apb(1'b0, OFS_CTRL, 32'h0);
		`CHK(rd, 32'hFD)
		apb(1'b1, OFS_MSEL, 32'hE4);
		apb(1'b0, OFS_MSEL, 32'h0);
		`CHK({er, rd[7:0], mask_sel}, {1'b0, 16'hE4E4})
		apb(1'b1, OFS_MODE, 32'h0);
		@(posedge clk);
		#1;
		`CHK(mask_sel, 8'h00)
		apb(1'b0, 12'h014, 32'h0);
		`CHK({er, rd}, {1'b1, 32'h0})
		$display("enhanced test done");
		@(posedge clk);
		reset_n <= 1'b0;
		@(posedge clk);
		#1;
		`CHK({buf_load, buffer_full, irq, mask_sel, pready, pslverr, prdata}, 45'h0)
		@(posedge clk);
		reset_n <= 1'b1;
		apb(1'b1, OFS_MSEL, 32'hFF);
		`CHK(er, 1'b1)
		apb(1'b1, OFS_MODE, 32'h1);
		apb(1'b0, OFS_MSEL, 32'h0);
		`CHK({er, rd}, {1'b0, 32'h0})
		$display("mid reset test done");
		complete_run();
	end
endmodule
